//--- src/port3_port4_function_select.sv
/*
 Pin function select for port3_bit3..7 and port4_bit0..3, APB register slave.
 Assumes pins arrive asynchronously and peripherals share the system clock.
*/
`timescale 1ns/1ps
module port3_port4_function_select
    import pin_mux_pkg::*;
#(
    parameter int P3N = P3_W,
    parameter int P4N = P4_W
) (
    input  wire logic                          clock,
    input  wire logic                          reset,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [pin_mux_pkg::ADDR_W-1:0] paddr,
    input  wire logic [pin_mux_pkg::DATA_W-1:0] pwdata,
    output logic      [pin_mux_pkg::DATA_W-1:0] prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [P3N-1:0]                p3In,
    output logic      [P3N-1:0]                p3Out,
    output logic      [P3N-1:0]                p3Oe,
    output logic      [P3N-1:0]                p3PullUp,
    input  wire logic [P4N-1:0]                p4In,
    output logic      [P4N-1:0]                p4Out,
    output logic      [P4N-1:0]                p4Oe,
    input  wire pin_mux_pkg::bus_s             busSig,
    input  wire pin_mux_pkg::serial_s          serialSig,
    output logic                               extBusMode,
    output logic                               bus16Mode,
    output logic                               holdReqIn,
    output logic                               readyIn,
    output logic                               serial0ClockIn,
    output logic                               serial0RxData,
    output logic                               serial1RxData
);
    import pin_mux_pkg::*;

    // Peripheral selected wins over port data and direction
    function automatic logic [1:0] pinMux(
        input logic sel,
        input logic perOut,
        input logic perOe,
        input logic datBit,
        input logic dirBit
    );
        logic [1:0] r;
        r = {datBit, dirBit};
        if (sel) begin
            r = {perOut, perOe};
        end
        return r;
    endfunction : pinMux

    ctrl_s               ctrl_r;
    ctrl_s               ctrl_nxt;
    logic [P3N-1:0]      p3Dat_r;
    logic [P3N-1:0]      p3Dat_nxt;
    logic [P3N-1:0]      p3Dir_r;
    logic [P3N-1:0]      p3Dir_nxt;
    logic [P3N-1:0]      p3Pul_r;
    logic [P3N-1:0]      p3Pul_nxt;
    logic [P4N-1:0]      p4Dat_r;
    logic [P4N-1:0]      p4Dat_nxt;
    logic [P4N-1:0]      p4Dir_r;
    logic [P4N-1:0]      p4Dir_nxt;
    logic [DATA_W-1:0]   rdat_r;
    logic [DATA_W-1:0]   rdat_nxt;
    logic                err_r;
    logic                err_nxt;
    logic [P3N-1:0]      p3Meta_r;
    logic [P3N-1:0]      p3Sync_r;
    logic [P4N-1:0]      p4Meta_r;
    logic [P4N-1:0]      p4Sync_r;
    logic [P3N-1:0]      p3Out_r;
    logic [P3N-1:0]      p3Out_nxt;
    logic [P3N-1:0]      p3Oe_r;
    logic [P3N-1:0]      p3Oe_nxt;
    logic [P3N-1:0]      p3Pu_r;
    logic [P3N-1:0]      p3Pu_nxt;
    logic [P4N-1:0]      p4Out_r;
    logic [P4N-1:0]      p4Out_nxt;
    logic [P4N-1:0]      p4Oe_r;
    logic [P4N-1:0]      p4Oe_nxt;
    logic [P3N-1:0]      sel3;
    logic [P3N-1:0]      per3Out;
    logic [P3N-1:0]      per3Oe;
    logic [P4N-1:0]      sel4;
    logic [P4N-1:0]      per4Out;
    logic [P4N-1:0]      per4Oe;
    logic                setup;
    logic                access;
    logic                hit;
    logic                strobeSel;
    logic                holdSel;
    logic                readySel;
    logic                clkSel;

    assign setup  = psel & ~penable;
    assign access = psel & penable;

    // Address decode
    always_comb begin
        case (paddr)
            OFF_CTRL, OFF_P3DAT, OFF_P3DIR, OFF_P3PUL,
            OFF_P4DAT, OFF_P4DIR, OFF_PINS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // Function selects from the mode bits
    always_comb begin
        strobeSel = ctrl_r.extBus & ctrl_r.bus16 & ctrl_r.strobeOe;
        holdSel   = ctrl_r.extBus & ctrl_r.holdEn;
        readySel  = ctrl_r.extBus & ctrl_r.readyEn;
        clkSel    = ctrl_r.extBus & ctrl_r.clkOutEn;
    end

    // Peripheral claims per pin; inputs claim with enable low
    always_comb begin
        sel3    = '0;
        per3Out = '0;
        per3Oe  = '0;
        // strobe pin falls back to port
        sel3[P3_STROBE]    = strobeSel;
        per3Out[P3_STROBE] = busSig.strobe;
        per3Oe[P3_STROBE]  = 1'b1;
        // hold pins fall back to port
        sel3[P3_HREQ]      = holdSel;
        sel3[P3_HACK]      = holdSel;
        per3Out[P3_HACK]   = busSig.holdAck;
        per3Oe[P3_HACK]    = 1'b1;
        // ready pin falls back to port
        sel3[P3_READY]     = readySel;
        // clock pin falls back to port
        sel3[P3_CLK]       = clkSel;
        per3Out[P3_CLK]    = busSig.busClock;
        per3Oe[P3_CLK]     = 1'b1;
    end

    always_comb begin
        sel4    = '0;
        per4Out = '0;
        per4Oe  = '0;
        sel4[P4_TX]    = serialSig.txEn;
        per4Out[P4_TX] = serialSig.txData;
        per4Oe[P4_TX]  = 1'b1;
        sel4[P4_SCLK]    = serialSig.clkEn;
        per4Out[P4_SCLK] = serialSig.clkOut;
        per4Oe[P4_SCLK]  = 1'b1;
        sel4[P4_RX0] = 1'b0;
        sel4[P4_RX1] = 1'b0;
    end

    genvar gi;
    generate
        for (gi = 0; gi < P3N; gi++) begin : g_p3
            always_comb begin
                {p3Out_nxt[gi], p3Oe_nxt[gi]} =
                    pinMux(sel3[gi], per3Out[gi], per3Oe[gi], p3Dat_r[gi], p3Dir_r[gi]);
                p3Pu_nxt[gi] = p3Pul_r[gi] & ~sel3[gi];
            end
        end
        for (gi = 0; gi < P4N; gi++) begin : g_p4
            always_comb begin
                {p4Out_nxt[gi], p4Oe_nxt[gi]} =
                    pinMux(sel4[gi], per4Out[gi], per4Oe[gi], p4Dat_r[gi], p4Dir_r[gi]);
            end
        end
    endgenerate

    // Register file next state
    always_comb begin
        ctrl_nxt  = ctrl_r;
        p3Dat_nxt = p3Dat_r;
        p3Dir_nxt = p3Dir_r;
        p3Pul_nxt = p3Pul_r;
        p4Dat_nxt = p4Dat_r;
        p4Dir_nxt = p4Dir_r;
        rdat_nxt  = rdat_r;
        err_nxt   = err_r;
        if (setup) begin
            // Read data staged in setup so it leaves a flip-flop
            err_nxt  = ~hit;
            rdat_nxt = '0;
            case (paddr)
                OFF_CTRL:  rdat_nxt[CTRL_W-1:0] = ctrl_r;
                OFF_P3DAT: rdat_nxt[P3N-1:0] = p3Dat_r;
                OFF_P3DIR: rdat_nxt[P3N-1:0] = p3Dir_r;
                OFF_P3PUL: rdat_nxt[P3N-1:0] = p3Pul_r;
                OFF_P4DAT: rdat_nxt[P4N-1:0] = p4Dat_r;
                OFF_P4DIR: rdat_nxt[P4N-1:0] = p4Dir_r;
                OFF_PINS: begin
                    rdat_nxt[P3N-1:0] = p3Sync_r;
                    rdat_nxt[PINS_P4_LSB +: P4N] = p4Sync_r;
                end
                default: rdat_nxt = '0;
            endcase
        end
        if (access && pwrite) begin
            case (paddr)
                OFF_CTRL:  ctrl_nxt  = ctrl_s'(pwdata[CTRL_W-1:0]);
                OFF_P3DAT: p3Dat_nxt = pwdata[P3N-1:0];
                OFF_P3DIR: p3Dir_nxt = pwdata[P3N-1:0];
                OFF_P3PUL: p3Pul_nxt = pwdata[P3N-1:0];
                OFF_P4DAT: p4Dat_nxt = pwdata[P4N-1:0];
                OFF_P4DIR: p4Dir_nxt = pwdata[P4N-1:0];
                default: ctrl_nxt = ctrl_r;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrl_r  <= ctrl_s'(CTRL_RST);
            p3Dat_r <= P3_RST;
            p3Dir_r <= P3_RST;
            p3Pul_r <= P3_RST;
            p4Dat_r <= P4_RST;
            p4Dir_r <= P4_RST;
            rdat_r  <= '0;
            err_r   <= 1'b0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            p3Dat_r <= p3Dat_nxt;
            p3Dir_r <= p3Dir_nxt;
            p3Pul_r <= p3Pul_nxt;
            p4Dat_r <= p4Dat_nxt;
            p4Dir_r <= p4Dir_nxt;
            rdat_r  <= rdat_nxt;
            err_r   <= err_nxt;
        end
    end

    // Pin registers and input synchronisers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            p3Meta_r <= P3_RST;
            p3Sync_r <= P3_RST;
            p4Meta_r <= P4_RST;
            p4Sync_r <= P4_RST;
            p3Out_r  <= P3_RST;
            p3Oe_r   <= P3_RST;
            p3Pu_r   <= P3_RST;
            p4Out_r  <= P4_RST;
            p4Oe_r   <= P4_RST;
        end else begin
            p3Meta_r <= p3In;
            p3Sync_r <= p3Meta_r;
            p4Meta_r <= p4In;
            p4Sync_r <= p4Meta_r;
            p3Out_r  <= p3Out_nxt;
            p3Oe_r   <= p3Oe_nxt;
            p3Pu_r   <= p3Pu_nxt;
            p4Out_r  <= p4Out_nxt;
            p4Oe_r   <= p4Oe_nxt;
        end
    end

    // One registered stage on pin drive keeps outputs glitch free
    assign p3Out    = p3Out_r;
    assign p3Oe     = p3Oe_r;
    assign p3PullUp = p3Pu_r;
    assign p4Out    = p4Out_r;
    assign p4Oe     = p4Oe_r;

    // hold request gated off when not claimed
    assign holdReqIn = holdSel & p3Sync_r[P3_HREQ];
    // ready forced true when not claimed, so no stall
    assign readyIn   = ~readySel | p3Sync_r[P3_READY];
    assign extBusMode = ctrl_r.extBus;
    assign bus16Mode  = ctrl_r.extBus & ctrl_r.bus16;
    assign serial0RxData  = p4Sync_r[P4_RX0];
    assign serial1RxData  = p4Sync_r[P4_RX1];
    // clock pin level back to unit
    assign serial0ClockIn = p4Sync_r[P4_SCLK];

    // Zero wait states; unmapped offsets answer with an error
    assign pready  = 1'b1;
    assign pslverr = access & err_r;
    assign prdata  = rdat_r;
endmodule : port3_port4_function_select

//--- src/pin_mux_pkg.sv
/*
 Shared constants and carriers for the port 3 / port 4 pin function select.
 Assumes a 32-bit APB master and peripherals on the same system clock.
*/
package pin_mux_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int P3_W   = 5;
    localparam int P4_W   = 4;
    localparam int CTRL_W = 6;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL  = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_P3DAT = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_P3DIR = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_P3PUL = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_P4DAT = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_P4DIR = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_PINS  = 8'h18;

    // Pin state register: port 4 levels start here
    localparam int PINS_P4_LSB = 8;

    // Reset values: all pins port inputs, no pull-up, single-chip mode
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
    localparam logic [P3_W-1:0]   P3_RST   = 5'h00;
    localparam logic [P4_W-1:0]   P4_RST   = 4'h0;

    // Port 3 pin slots (port3_bit3 .. port3_bit7)
    localparam int P3_STROBE = 0;
    localparam int P3_HREQ   = 1;
    localparam int P3_HACK   = 2;
    localparam int P3_READY  = 3;
    localparam int P3_CLK    = 4;

    // Port 4 pin slots (port4_bit0 .. port4_bit3)
    localparam int P4_TX   = 0;
    localparam int P4_SCLK = 1;
    localparam int P4_RX0  = 2;
    localparam int P4_RX1  = 3;

    // Control register layout, bit 0 is extBus
    typedef struct packed {
        logic clkOutEn;
        logic readyEn;
        logic holdEn;
        logic strobeOe;
        logic bus16;
        logic extBus;
    } ctrl_s;

    // Outputs from the external bus controller
    typedef struct packed {
        logic strobe;
        logic holdAck;
        logic busClock;
    } bus_s;

    // Outputs from the first serial unit
    typedef struct packed {
        logic txData;
        logic txEn;
        logic clkOut;
        logic clkEn;
    } serial_s;
endpackage : pin_mux_pkg

//--- sim/pin_mux_assertions.sv
/*
 Port-level checks for the pin function select.
 Assumes one clock and an async active-high reset.
*/
`timescale 1ns/1ps
module pin_mux_assertions #(
    parameter int P3N = pin_mux_pkg::P3_W,
    parameter int P4N = pin_mux_pkg::P4_W
) (
    input wire logic                 clock,
    input wire logic                 reset,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic [P3N-1:0]       p3In,
    input wire logic [P4N-1:0]       p4In,
    input wire logic [P4N-1:0]       p4Out,
    input wire logic [P4N-1:0]       p4Oe,
    input wire pin_mux_pkg::serial_s serialSig,
    input wire logic                 extBusMode,
    input wire logic                 bus16Mode,
    input wire logic                 holdReqIn,
    input wire logic                 readyIn,
    input wire logic                 serial0RxData,
    input wire logic                 serial1RxData
);
    import pin_mux_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    sequence apbAccess;
        psel && penable;
    endsequence
    // Synchroniser needs two clean edges
    sequence outOfReset;
        !$past(reset) && !$past(reset, 2);
    endsequence
    a_ready_const: assert property (pready)
        else $error("pready low");
    a_err_access: assert property (pslverr |-> apbAccess)
        else $error("slave error outside access");
    a_width_mode: assert property (bus16Mode |-> extBusMode)
        else $error("16-bit width without external bus");
    a_hold_single: assert property (!extBusMode |-> !holdReqIn)
        else $error("hold request seen in single-chip mode");
    a_ready_single: assert property (!extBusMode |-> readyIn)
        else $error("ready held off in single-chip mode");
    a_hold_sample: assert property (holdReqIn |-> extBusMode && $past(p3In[P3_HREQ], 2))
        else $error("hold request not from its pin");
    a_ready_sample: assert property (!readyIn |-> extBusMode && !$past(p3In[P3_READY], 2))
        else $error("ready not from its pin");
    a_tx_drive: assert property (!$past(reset) && $past(serialSig.txEn) |->
        p4Oe[P4_TX] && p4Out[P4_TX] == $past(serialSig.txData))
        else $error("transmit pin not driven by serial unit");
    a_sclk_drive: assert property (!$past(reset) && $past(serialSig.clkEn) |->
        p4Oe[P4_SCLK] && p4Out[P4_SCLK] == $past(serialSig.clkOut))
        else $error("serial clock pin not driven by serial unit");
    a_rx_follow: assert property (outOfReset |-> serial0RxData == $past(p4In[P4_RX0], 2)
        && serial1RxData == $past(p4In[P4_RX1], 2))
        else $error("receive data not following its pin");
endmodule : pin_mux_assertions

bind port3_port4_function_select pin_mux_assertions #(.P3N(P3N), .P4N(P4N)) u_chk (
    .clock, .reset, .psel, .penable, .pready, .pslverr, .p3In, .p4In, .p4Out, .p4Oe,
    .serialSig, .extBusMode, .bus16Mode, .holdReqIn, .readyIn, .serial0RxData, .serial1RxData
);

//--- sim/pin_partner.sv
/*
 Far side of the shared pins: bus devices and serial peers.
 Assumes device pin outputs come from the same clock.
*/
`timescale 1ns/1ps
module pin_partner (
    input  wire logic                         clock,
    input  wire logic                         floatPins,
    input  wire logic [pin_mux_pkg::P3_W-1:0] drv3,
    input  wire logic [pin_mux_pkg::P4_W-1:0] drv4,
    input  wire logic [pin_mux_pkg::P3_W-1:0] p3Out,
    input  wire logic [pin_mux_pkg::P3_W-1:0] p3Oe,
    input  wire logic [pin_mux_pkg::P3_W-1:0] p3PullUp,
    input  wire logic [pin_mux_pkg::P4_W-1:0] p4Out,
    input  wire logic [pin_mux_pkg::P4_W-1:0] p4Oe,
    output logic      [pin_mux_pkg::P3_W-1:0] p3In,
    output logic      [pin_mux_pkg::P4_W-1:0] p4In
);
    import pin_mux_pkg::*;
    logic drift_r = 1'b0;
    logic drift_nxt;
    // Released lines without pull-up toggle so a stale level never passes for a drive
    always_comb begin
        drift_nxt = ~drift_r;
    end
    always_ff @(posedge clock) begin
        drift_r <= drift_nxt;
    end
    assign p3In = (p3Oe & p3Out) | (~p3Oe & (floatPins ? (p3PullUp | {P3_W{drift_r}}) : drv3));
    assign p4In = (p4Oe & p4Out) | (~p4Oe & (floatPins ? {P4_W{drift_r}} : drv4));
endmodule : pin_partner

//--- sim/port3_port4_function_select_tb.sv
/*
 Self-checking bench for the pin function select.
 Assumes the partner model resolves every pin level.
*/
`timescale 1ns/1ps
module port3_port4_function_select_tb;
    import pin_mux_pkg::*;
    logic              clock = 1'b0, reset = 1'b1, floatPins = 1'b0;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, q;
    logic [P3_W-1:0]   p3In, p3Out, p3Oe, p3PullUp, drv3 = '0, d3, dir3, pul3, sel3, oe3, out3, lv3;
    logic [P4_W-1:0]   p4In, p4Out, p4Oe, drv4 = '0, d4, dir4, sel4, oe4, out4, lv4;
    logic              extBusMode, bus16Mode, holdReqIn, readyIn, s0Clk, s0Rx, s1Rx;
    logic              sS, sH, sR, sC;
    bus_s              busSig = '0;
    serial_s           serialSig = '0;
    ctrl_s             c;
    int                badCount = 0, samplesChecked = 0;

    port3_port4_function_select dut (
        .clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .p3In, .p3Out, .p3Oe, .p3PullUp, .p4In, .p4Out, .p4Oe, .busSig, .serialSig,
        .extBusMode, .bus16Mode, .holdReqIn, .readyIn, .serial0ClockIn(s0Clk),
        .serial0RxData(s0Rx), .serial1RxData(s1Rx)
    );
    pin_partner partner (
        .clock, .floatPins, .drv3, .drv4, .p3Out, .p3Oe, .p3PullUp, .p4Out, .p4Oe, .p3In, .p4In
    );

    always #5 clock = ~clock;

    task automatic endSim();
        if (badCount == 0 && samplesChecked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : endSim

    task automatic chk(input string n, input logic [DATA_W-1:0] x, input logic [DATA_W-1:0] g);
        samplesChecked++;
        if (g !== x) begin
            badCount++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Only the watchdog ends a stalled access
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    initial begin
        repeat (20000) @(posedge clock);
        badCount++;
        endSim();
    end

    initial begin
        void'($urandom(55));
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        apb(1'b1, OFF_PINS, 32'hffffffff);
        chk("pins write error", 32'h0, {31'h0, e});
        for (int a = 0; a < 7; a++) begin
            apb(1'b0, 8'(a * 4), '0);
            chk("reset value", '0, q);
        end
        apb(1'b1, 8'h1c, 32'hffffffff);
        chk("unmapped error", 32'h1, {31'h0, e});
        apb(1'b0, OFF_CTRL, '0);
        chk("ctrl kept", '0, q);
        for (int i = 0; i < 64; i++) begin
            c = 6'(i);
            d3 = 5'($urandom());
            dir3 = 5'($urandom());
            pul3 = 5'($urandom());
            d4 = 4'($urandom());
            dir4 = 4'($urandom()) & 4'h3;
            apb(1'b1, OFF_CTRL, 32'(c));
            apb(1'b1, OFF_P3DAT, 32'(d3));
            apb(1'b1, OFF_P3DIR, 32'(dir3));
            apb(1'b1, OFF_P3PUL, 32'(pul3));
            apb(1'b1, OFF_P4DAT, 32'(d4));
            apb(1'b1, OFF_P4DIR, 32'(dir4));
            busSig <= 3'($urandom());
            serialSig <= 4'($urandom());
            drv3 <= 5'($urandom());
            drv4 <= 4'($urandom());
            repeat (4) @(posedge clock);
            sS = c.extBus & c.bus16 & c.strobeOe;
            sH = c.extBus & c.holdEn;
            sR = c.extBus & c.readyEn;
            sC = c.extBus & c.clkOutEn;
            sel3 = {sC, sR, sH, sH, sS};
            oe3 = (dir3 & ~sel3) | {sC, 1'b0, sH, 1'b0, sS};
            out3 = {sC ? busSig.busClock : d3[4], d3[3], sH ? busSig.holdAck : d3[2], d3[1:0]};
            out3[0] = sS ? busSig.strobe : d3[0];
            sel4 = {2'b00, serialSig.clkEn, serialSig.txEn};
            oe4 = (dir4 & ~sel4) | sel4;
            out4 = {d4[3:2], sel4[1] ? serialSig.clkOut : d4[1], sel4[0] ? serialSig.txData : d4[0]};
            lv3 = (oe3 & out3) | (~oe3 & drv3);
            lv4 = (oe4 & out4) | (~oe4 & drv4);
            chk("p3Oe", oe3, p3Oe);
            chk("p3Out", out3 & oe3, p3Out & oe3);
            chk("p3PullUp", pul3 & ~sel3, p3PullUp);
            chk("p4Oe", oe4, p4Oe);
            chk("p4Out", out4 & oe4, p4Out & oe4);
            chk("modes", {c.extBus, c.extBus & c.bus16}, {extBusMode, bus16Mode});
            chk("hold ready", {sH & lv3[1], sR ? lv3[3] : 1'b1}, {holdReqIn, readyIn});
            chk("serial in", lv4[3:1], {s1Rx, s0Rx, s0Clk});
            apb(1'b0, OFF_PINS, '0);
            chk("pins", {lv4, 3'h0, lv3}, q);
            apb(1'b0, OFF_CTRL, '0);
            chk("ctrl", 32'(c), q);
            chk("mapped error", 32'h0, {31'h0, e});
        end
        apb(1'b1, OFF_CTRL, '0);
        apb(1'b1, OFF_P3DIR, '0);
        apb(1'b1, OFF_P3PUL, 32'h1f);
        floatPins <= 1'b1;
        repeat (4) @(posedge clock);
        apb(1'b0, OFF_PINS, '0);
        chk("pull level", 32'h1f, {27'h0, q[4:0]});
        endSim();
    end
endmodule : port3_port4_function_select_tb
